// *** tsom_observe.sv ***
// observation multiplexer top: register slave and two pin selectors
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "tsom_cfg.svh"

module tsom_observe #(
	parameter int DAC_W = 6,
	parameter int ADC_W = 4,
	parameter int BUS_W = 8,
	parameter int ADDR_W = 18
) (
	input wire logic clock_i,
	input wire logic rst_i,
	// register bus, byte addressed
	input wire logic [ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// internal sources
	input wire logic [DAC_W-1:0] first_correlator_out_i,
	input wire logic [DAC_W-1:0] second_correlator_out_i,
	input wire logic [DAC_W-1:0] minimum_level_threshold_i,
	input wire logic [ADC_W-1:0] adc_i_sample_i,
	input wire logic [ADC_W-1:0] adc_q_sample_i,
	input wire logic production_test_i,
	input wire logic sic_clock_i,
	input wire logic error_indicator_bit_i,
	input wire tsom_pkg::tsom_rate_type rate_i,
	input wire tsom_pkg::tsom_phase_type tx_phase_i,
	input wire tsom_pkg::tsom_phase_type rx_phase_i,
	input wire logic [BUS_W-1:0] test_bus_i,
	// first observation pin
	output logic first_observe_pin_oe_o,
	output logic first_observe_pin_level_o,
	output logic first_observe_pin_dac_enable_o,
	output logic [DAC_W-1:0] first_observe_pin_dac_code_o,
	// second observation pin
	output logic second_observe_pin_oe_o,
	output logic second_observe_pin_level_o,
	output logic second_observe_pin_dac_enable_o,
	output logic [DAC_W-1:0] second_observe_pin_dac_code_o
);

	localparam int NPINS = 2;

	// register state
	logic [7:0] observe_pin_select_q;
	logic [DAC_W-1:0] first_test_dac_value_q;
	logic [DAC_W-1:0] second_test_dac_value_q;
	logic [`TSOM_BUSBIT_MSB:0] test_bus_bit_choice_q;

	// bus decode
	logic [15:0] reg_index;
	logic wr_low_byte;
	logic hit_select;
	logic hit_dac1;
	logic hit_dac2;
	logic hit_status;
	logic hit_busbit;
	logic read_pending_q;
	logic [31:0] read_word_d;
	logic [31:0] readdata_q;

	// shared sources for both pins
	logic tx_strobe;
	logic rx_strobe;
	logic sc_strobe;
	logic bus_bit_q;

	// per-pin signals, index 0 is the first pin
	logic [3:0] pin_select [NPINS];
	logic [DAC_W-1:0] pin_own_dac [NPINS];
	logic pin_oe [NPINS];
	logic pin_level [NPINS];
	logic pin_dac_en [NPINS];
	logic [DAC_W-1:0] pin_code [NPINS];

	// low two address bits are lane offsets inside the word
	assign reg_index = 16'(avs_address_i[ADDR_W-1:2]);
	assign hit_select = (reg_index == `TSOM_IDX_SELECT);
	assign hit_dac1 = (reg_index == `TSOM_IDX_DAC1);
	assign hit_dac2 = (reg_index == `TSOM_IDX_DAC2);
	assign hit_status = (reg_index == `TSOM_IDX_STATUS);
	assign hit_busbit = (reg_index == `TSOM_IDX_BUSBIT);

	// all registers fit in eight bits and live in byte lane 0
	assign wr_low_byte = avs_write_i && avs_byteenable_i[0];

	// writes complete at once; reads wait one cycle for registered data
	assign avs_waitrequest_o = avs_read_i && !read_pending_q;
	assign avs_readdata_o = readdata_q;

	// selector register; each nibble steers only its own pin
	// write applies next edge
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			observe_pin_select_q <= `TSOM_SELECT_RST;
		end else if (wr_low_byte && hit_select) begin
			observe_pin_select_q <= avs_writedata_i[7:0];
		end
	end

	// first dac value; upper bits of the byte are not stored
	// six stored bits
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			first_test_dac_value_q <= `TSOM_DAC_RST;
		end else if (wr_low_byte && hit_dac1) begin
			first_test_dac_value_q <= avs_writedata_i[`TSOM_DAC_MSB:0];
		end
	end

	// second dac value, same layout as the first
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			second_test_dac_value_q <= `TSOM_DAC_RST;
		end else if (wr_low_byte && hit_dac2) begin
			second_test_dac_value_q <= avs_writedata_i[`TSOM_DAC_MSB:0];
		end
	end

	// test bus bit choice
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			test_bus_bit_choice_q <= `TSOM_BUSBIT_RST;
		end else if (wr_low_byte && hit_busbit) begin
			test_bus_bit_choice_q <= avs_writedata_i[`TSOM_BUSBIT_MSB:0];
		end
	end

	// read mux; unmapped indices and reserved bits read as zero
	always_comb begin
		read_word_d = 32'h0000_0000;
		if (hit_select) begin
			read_word_d[7:0] = observe_pin_select_q;
		end
		if (hit_dac1) begin
			read_word_d[`TSOM_DAC_MSB:0] = first_test_dac_value_q;
		end
		if (hit_dac2) begin
			read_word_d[`TSOM_DAC_MSB:0] = second_test_dac_value_q;
		end
		if (hit_busbit) begin
			read_word_d[`TSOM_BUSBIT_MSB:0] = test_bus_bit_choice_q;
		end
		// live pin state so software can confirm what the pins carry
		if (hit_status) begin
			read_word_d[0] = pin_oe[0];
			read_word_d[1] = pin_level[0];
			read_word_d[2] = pin_dac_en[0];
			read_word_d[3] = pin_oe[1];
			read_word_d[4] = pin_level[1];
			read_word_d[5] = pin_dac_en[1];
		end
	end

	// read handshake: capture in the waited cycle, release next edge
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			read_pending_q <= 1'b0;
		end else begin
			read_pending_q <= avs_read_i && !read_pending_q;
		end
	end

	// read data held until the next read captures
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			readdata_q <= 32'h0000_0000;
		end else if (avs_read_i && !read_pending_q) begin
			readdata_q <= read_word_d;
		end
	end

	// pick one test bus bit; registered to match the frame strobes
	// bus bit pick
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			bus_bit_q <= 1'b0;
		end else begin
			bus_bit_q <= test_bus_i[test_bus_bit_choice_q];
		end
	end

	// frame strobes shared by both pins
	tsom_frame_strobes u_strobes (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.rate_i(rate_i),
		.tx_phase_i(tx_phase_i),
		.rx_phase_i(rx_phase_i),
		.transmit_active_strobe_o(tx_strobe),
		.receive_active_strobe_o(rx_strobe),
		.subcarrier_strobe_o(sc_strobe)
	);

	// selector nibble and dac value per pin
	// first pin nibble
	assign pin_select[0] = observe_pin_select_q[`TSOM_SEL1_MSB:`TSOM_SEL1_LSB];
	assign pin_select[1] = observe_pin_select_q[`TSOM_SEL2_MSB:`TSOM_SEL2_LSB];
	assign pin_own_dac[0] = first_test_dac_value_q;
	assign pin_own_dac[1] = second_test_dac_value_q;

	// one selector per pin, identical code table
	generate
		for (genvar p = 0; p < NPINS; p++) begin : g_pin
			tsom_pin_mux #(
				.DAC_W(DAC_W),
				.ADC_W(ADC_W)
			) u_mux (
				.clock_i(clock_i),
				.rst_i(rst_i),
				.select_i(pin_select[p]),
				.own_dac_i(pin_own_dac[p]),
				.first_correlator_out_i(first_correlator_out_i),
				.second_correlator_out_i(second_correlator_out_i),
				.minimum_level_threshold_i(minimum_level_threshold_i),
				.adc_i_sample_i(adc_i_sample_i),
				.adc_q_sample_i(adc_q_sample_i),
				.production_test_i(production_test_i),
				.sic_clock_i(sic_clock_i),
				.error_indicator_bit_i(error_indicator_bit_i),
				.transmit_active_strobe_i(tx_strobe),
				.receive_active_strobe_i(rx_strobe),
				.subcarrier_strobe_i(sc_strobe),
				.test_bus_bit_i(bus_bit_q),
				.pin_oe_o(pin_oe[p]),
				.pin_level_o(pin_level[p]),
				.dac_enable_o(pin_dac_en[p]),
				.dac_code_o(pin_code[p])
			);
		end
	endgenerate

	// first pin outputs
	assign first_observe_pin_oe_o = pin_oe[0];
	assign first_observe_pin_level_o = pin_level[0];
	assign first_observe_pin_dac_enable_o = pin_dac_en[0];
	assign first_observe_pin_dac_code_o = pin_code[0];

	// second pin outputs
	assign second_observe_pin_oe_o = pin_oe[1];
	assign second_observe_pin_level_o = pin_level[1];
	assign second_observe_pin_dac_enable_o = pin_dac_en[1];
	assign second_observe_pin_dac_code_o = pin_code[1];

endmodule : tsom_observe

`default_nettype wire

// *** tsom_cfg.svh ***
// constants for the test signal observation multiplexer
`ifndef TSOM_CFG_SVH
`define TSOM_CFG_SVH

// register indices; byte address is four times the index
`define TSOM_IDX_SELECT 16'h6328
`define TSOM_IDX_DAC1 16'h6329
`define TSOM_IDX_DAC2 16'h632A
`define TSOM_IDX_STATUS 16'h6330
`define TSOM_IDX_BUSBIT 16'h6331

// field positions
`define TSOM_SEL1_MSB 7
`define TSOM_SEL1_LSB 4
`define TSOM_SEL2_MSB 3
`define TSOM_SEL2_LSB 0
`define TSOM_DAC_MSB 5
`define TSOM_BUSBIT_MSB 2

// reset values
`define TSOM_SELECT_RST 8'h00
`define TSOM_DAC_RST 6'h00
`define TSOM_BUSBIT_RST 3'h0

`endif

// *** tsom_pkg.sv ***
// types shared by the observation multiplexer files
`default_nettype none

package tsom_pkg;

	// source codes of each pin selector
	typedef enum logic [3:0] {
		TSOM_SRC_TRISTATE = 4'b0000,
		TSOM_SRC_OWN_DAC = 4'b0001,
		TSOM_SRC_FIRST_CORR = 4'b0010,
		TSOM_SRC_SECOND_CORR = 4'b0011,
		TSOM_SRC_MIN_LEVEL = 4'b0100,
		TSOM_SRC_ADC_I = 4'b0101,
		TSOM_SRC_ADC_Q = 4'b0110,
		TSOM_SRC_ADC_IQ = 4'b0111,
		TSOM_SRC_PROD_TEST = 4'b1000,
		TSOM_SRC_SIC_CLOCK = 4'b1001,
		TSOM_SRC_ERROR = 4'b1010,
		TSOM_SRC_LOW = 4'b1011,
		TSOM_SRC_TX_ACTIVE = 4'b1100,
		TSOM_SRC_RX_ACTIVE = 4'b1101,
		TSOM_SRC_SUBCARRIER = 4'b1110,
		TSOM_SRC_BUS_BIT = 4'b1111
	} tsom_source_type;

	// contactless bit rate
	typedef enum logic [1:0] {
		TSOM_RATE_106 = 2'b00,
		TSOM_RATE_212 = 2'b01,
		TSOM_RATE_424 = 2'b10
	} tsom_rate_type;

	// part of a frame the coder or decoder is in
	typedef enum logic [2:0] {
		TSOM_PH_IDLE = 3'b000,
		TSOM_PH_START = 3'b001,
		TSOM_PH_PREAMBLE = 3'b010,
		TSOM_PH_PRE_TAIL = 3'b011,
		TSOM_PH_SYNC = 3'b100,
		TSOM_PH_DATA = 3'b101,
		TSOM_PH_PARITY = 3'b110,
		TSOM_PH_CRC = 3'b111
	} tsom_phase_type;

endpackage : tsom_pkg

`default_nettype wire

// *** tsom_frame_strobes.sv ***
// frame activity strobes derived from frame phase and bit rate
`timescale 1ns/1ns
`default_nettype none

module tsom_frame_strobes (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire tsom_pkg::tsom_rate_type rate_i,
	input wire tsom_pkg::tsom_phase_type tx_phase_i,
	input wire tsom_pkg::tsom_phase_type rx_phase_i,
	output logic transmit_active_strobe_o,
	output logic receive_active_strobe_o,
	output logic subcarrier_strobe_o
);

	logic slow;
	logic tx_d;
	logic rx_d;
	logic sc_d;

	assign slow = (rate_i == tsom_pkg::TSOM_RATE_106);

	// transmit window, framing differs between slow and fast rates
	// transmit window shaping
	always_comb begin
		case (tx_phase_i)
			tsom_pkg::TSOM_PH_START: tx_d = slow;
			tsom_pkg::TSOM_PH_PARITY: tx_d = slow;
			tsom_pkg::TSOM_PH_PREAMBLE: tx_d = !slow;
			tsom_pkg::TSOM_PH_PRE_TAIL: tx_d = !slow;
			tsom_pkg::TSOM_PH_SYNC: tx_d = !slow;
			tsom_pkg::TSOM_PH_DATA: tx_d = 1'b1;
			tsom_pkg::TSOM_PH_CRC: tx_d = 1'b1;
			default: tx_d = 1'b0;
		endcase
	end

	// receive window; parity only exists at the slow rate
	// receive window shaping
	always_comb begin
		case (rx_phase_i)
			tsom_pkg::TSOM_PH_PARITY: rx_d = slow;
			tsom_pkg::TSOM_PH_DATA: rx_d = 1'b1;
			tsom_pkg::TSOM_PH_CRC: rx_d = 1'b1;
			default: rx_d = 1'b0;
		endcase
	end

	// subcarrier seen from preamble tail on; held low at the slow rate
	// subcarrier window shaping
	always_comb begin
		case (rx_phase_i)
			tsom_pkg::TSOM_PH_PRE_TAIL: sc_d = !slow;
			tsom_pkg::TSOM_PH_SYNC: sc_d = !slow;
			tsom_pkg::TSOM_PH_DATA: sc_d = !slow;
			tsom_pkg::TSOM_PH_CRC: sc_d = !slow;
			default: sc_d = 1'b0;
		endcase
	end

	// registered so the pins never see decode glitches
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			transmit_active_strobe_o <= 1'b0;
			receive_active_strobe_o <= 1'b0;
			subcarrier_strobe_o <= 1'b0;
		end else begin
			transmit_active_strobe_o <= tx_d;
			receive_active_strobe_o <= rx_d;
			subcarrier_strobe_o <= sc_d;
		end
	end

endmodule : tsom_frame_strobes

`default_nettype wire

// *** tsom_pin_mux.sv ***
// source selection for one observation pin
`timescale 1ns/1ns
`default_nettype none

module tsom_pin_mux #(
	parameter int DAC_W = 6,
	parameter int ADC_W = 4
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [3:0] select_i,
	input wire logic [DAC_W-1:0] own_dac_i,
	input wire logic [DAC_W-1:0] first_correlator_out_i,
	input wire logic [DAC_W-1:0] second_correlator_out_i,
	input wire logic [DAC_W-1:0] minimum_level_threshold_i,
	input wire logic [ADC_W-1:0] adc_i_sample_i,
	input wire logic [ADC_W-1:0] adc_q_sample_i,
	input wire logic production_test_i,
	input wire logic sic_clock_i,
	input wire logic error_indicator_bit_i,
	input wire logic transmit_active_strobe_i,
	input wire logic receive_active_strobe_i,
	input wire logic subcarrier_strobe_i,
	input wire logic test_bus_bit_i,
	output logic pin_oe_o,
	output logic pin_level_o,
	output logic dac_enable_o,
	output logic [DAC_W-1:0] dac_code_o
);

	logic oe_d;
	logic level_d;
	logic dac_en_d;
	logic [DAC_W-1:0] code_d;
	logic [DAC_W-1:0] adc_i_wide;
	logic [DAC_W-1:0] adc_q_wide;
	logic [DAC_W-1:0] adc_sum;

	// adc samples sit in the top of the dac range; the sum is halved
	assign adc_i_wide = {adc_i_sample_i, {(DAC_W-ADC_W){1'b0}}};
	assign adc_q_wide = {adc_q_sample_i, {(DAC_W-ADC_W){1'b0}}};
	assign adc_sum = DAC_W'((({1'b0, adc_i_wide} + {1'b0, adc_q_wide}) >> 1));

	// decode the selector into drive enable, level and dac code
	always_comb begin
		oe_d = 1'b1;
		level_d = 1'b0;
		dac_en_d = 1'b0;
		code_d = '0;
		case (tsom_pkg::tsom_source_type'(select_i))
			tsom_pkg::TSOM_SRC_TRISTATE: oe_d = 1'b0;
			tsom_pkg::TSOM_SRC_OWN_DAC: begin
				dac_en_d = 1'b1;
				code_d = own_dac_i;
			end
			tsom_pkg::TSOM_SRC_FIRST_CORR: begin
				dac_en_d = 1'b1;
				code_d = first_correlator_out_i;
			end
			tsom_pkg::TSOM_SRC_SECOND_CORR: begin
				dac_en_d = 1'b1;
				code_d = second_correlator_out_i;
			end
			tsom_pkg::TSOM_SRC_MIN_LEVEL: begin
				dac_en_d = 1'b1;
				code_d = minimum_level_threshold_i;
			end
			tsom_pkg::TSOM_SRC_ADC_I: begin
				dac_en_d = 1'b1;
				code_d = adc_i_wide;
			end
			tsom_pkg::TSOM_SRC_ADC_Q: begin
				dac_en_d = 1'b1;
				code_d = adc_q_wide;
			end
			tsom_pkg::TSOM_SRC_ADC_IQ: begin
				dac_en_d = 1'b1;
				code_d = adc_sum;
			end
			tsom_pkg::TSOM_SRC_PROD_TEST: level_d = production_test_i;
			// companion clock, seen at sample rate only
			tsom_pkg::TSOM_SRC_SIC_CLOCK: level_d = sic_clock_i;
			tsom_pkg::TSOM_SRC_ERROR: level_d = error_indicator_bit_i;
			tsom_pkg::TSOM_SRC_LOW: level_d = 1'b0;
			tsom_pkg::TSOM_SRC_TX_ACTIVE: level_d = transmit_active_strobe_i;
			tsom_pkg::TSOM_SRC_RX_ACTIVE: level_d = receive_active_strobe_i;
			tsom_pkg::TSOM_SRC_SUBCARRIER: level_d = subcarrier_strobe_i;
			tsom_pkg::TSOM_SRC_BUS_BIT: level_d = test_bus_bit_i;
			default: oe_d = 1'b0;
		endcase
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			pin_oe_o <= 1'b0;
			pin_level_o <= 1'b0;
			dac_enable_o <= 1'b0;
			dac_code_o <= '0;
		end else begin
			pin_oe_o <= oe_d;
			pin_level_o <= level_d;
			dac_enable_o <= dac_en_d;
			dac_code_o <= code_d;
		end
	end

endmodule : tsom_pin_mux

`default_nettype wire

// *** tsom_probe.sv ***
// test equipment model that probes one observation pin
`timescale 1ns/1ns
`default_nettype none

module tsom_probe (
	input wire logic oe_i,
	input wire logic level_i,
	input wire logic dac_en_i,
	input wire logic [5:0] code_i,
	output logic [8:0] seen_o
);
	// pin read through the pull-down, so an undriven pin reads low and never a stale level
	assign seen_o = {oe_i, dac_en_i, oe_i & ~dac_en_i & level_i, dac_en_i ? code_i : 6'h00};
endmodule : tsom_probe
`default_nettype wire

// *** tsom_observe_properties.sv ***
// assertion checker on the observation multiplexer top ports
`timescale 1ns/1ns
`default_nettype none
`include "tsom_cfg.svh"

module tsom_observe_props #(
	parameter int DAC_W = 6,
	parameter int ADC_W = 4,
	parameter int BUS_W = 8,
	parameter int ADDR_W = 18
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic [DAC_W-1:0] first_correlator_out_i,
	input wire logic [ADC_W-1:0] adc_i_sample_i,
	input wire logic [ADC_W-1:0] adc_q_sample_i,
	input wire logic production_test_i,
	input wire logic sic_clock_i,
	input wire logic error_indicator_bit_i,
	input wire tsom_pkg::tsom_rate_type rate_i,
	input wire tsom_pkg::tsom_phase_type tx_phase_i,
	input wire tsom_pkg::tsom_phase_type rx_phase_i,
	input wire logic [BUS_W-1:0] test_bus_i,
	input wire logic first_observe_pin_oe_o,
	input wire logic first_observe_pin_level_o,
	input wire logic first_observe_pin_dac_enable_o,
	input wire logic [DAC_W-1:0] first_observe_pin_dac_code_o,
	input wire logic second_observe_pin_oe_o,
	input wire logic second_observe_pin_level_o,
	input wire logic [DAC_W-1:0] second_observe_pin_dac_code_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	logic [7:0] sel_q;
	logic [5:0] dac1_q;
	logic [2:0] choice_q;
	logic [ADDR_W-3:0] idx;
	logic bit_now;
	logic lvl_now;
	// current picks, so the assertions stay short
	assign idx = avs_address_i[ADDR_W-1:2];
	assign bit_now = test_bus_i[choice_q];
	assign lvl_now = sel_q[5] ? error_indicator_bit_i : sel_q[4] ? sic_clock_i : production_test_i;
	// shadow of what software wrote; writes never wait, so the request edge stores
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			sel_q <= 8'h00;
			dac1_q <= 6'h00;
			choice_q <= 3'h0;
		end else if (avs_write_i && avs_byteenable_i[0]) begin
			if (idx == `TSOM_IDX_SELECT)
				sel_q <= avs_writedata_i[7:0];
			if (idx == `TSOM_IDX_DAC1)
				dac1_q <= avs_writedata_i[5:0];
			if (idx == `TSOM_IDX_BUSBIT)
				choice_q <= avs_writedata_i[2:0];
		end
	end
	// expected strobe level from code, rate and the phases two cycles back
	function automatic logic strobe_exp(input logic [3:0] c, input logic [1:0] r,
		input logic [2:0] t, input logic [2:0] x);
		logic [7:0] m;
		if (c == 4'hC)
			m = (r == 2'h0) ? 8'hE2 : 8'hBC;
		else if (c == 4'hD)
			m = (r == 2'h0) ? 8'hE0 : 8'hA0;
		else
			m = (r == 2'h0) ? 8'h00 : 8'hB8;
		strobe_exp = m[(c == 4'hC) ? t : x];
	endfunction : strobe_exp

	a_tristate_idle: assert property (sel_q[7:4] == 4'h0 |=>
		!first_observe_pin_oe_o && !first_observe_pin_dac_enable_o)
		else $error("first pin driven under code zero");
	a_low_forced: assert property (sel_q[3:0] == 4'hB |=>
		second_observe_pin_oe_o && !second_observe_pin_level_o)
		else $error("second pin not low under low code");
	a_own_dac: assert property (sel_q[7:4] == 4'h1 |=> first_observe_pin_dac_enable_o &&
		first_observe_pin_dac_code_o == $past(dac1_q))
		else $error("first pin does not show its dac value");
	a_corr_route: assert property (sel_q[3:0] == 4'h2 |=>
		second_observe_pin_dac_code_o == $past(first_correlator_out_i))
		else $error("second pin misses first correlator");
	a_iq_average: assert property (sel_q[7:4] == 4'h7 |=> first_observe_pin_dac_code_o ==
		DAC_W'(({1'b0, $past(adc_i_sample_i), 2'h0} + {1'b0, $past(adc_q_sample_i), 2'h0}) >> 1))
		else $error("combined sample wrong");
	a_level_route: assert property (sel_q[7:4] inside {4'h8, 4'h9, 4'hA} |=>
		first_observe_pin_oe_o && first_observe_pin_level_o == $past(lvl_now))
		else $error("plain level source not routed");
	a_strobe_route: assert property (sel_q[3:2] == 2'h3 && sel_q[3:0] != 4'hF |=>
		second_observe_pin_level_o == strobe_exp($past(sel_q[3:0]), $past(rate_i, 2),
		$past(tx_phase_i, 2), $past(rx_phase_i, 2)))
		else $error("frame strobe wrong");
	a_bus_bit: assert property (sel_q[7:4] == 4'hF |=>
		first_observe_pin_level_o == $past(bit_now, 2))
		else $error("test bus bit wrong");
	a_dac_readback: assert property (avs_read_i && !avs_waitrequest_o &&
		idx == `TSOM_IDX_DAC1 |-> avs_readdata_o[7:0] == {2'h0, $past(dac1_q)})
		else $error("dac register reads wrong");
	a_read_wait: assert property ($rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
		else $error("read wait not one cycle");
endmodule : tsom_observe_props

bind tsom_observe tsom_observe_props #(.DAC_W(DAC_W), .ADC_W(ADC_W), .BUS_W(BUS_W),
	.ADDR_W(ADDR_W)) props_u (.*);
`default_nettype wire

// *** test_test_signal_observe_mux.sv ***
// self-checking bench for the observation multiplexer
`timescale 1ns/1ns
`default_nettype none
`include "tsom_cfg.svh"

module test_test_signal_observe_mux;
	logic clock_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
	logic [17:0] avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o;
	logic [3:0] avs_byteenable_i, adc_i_sample_i, adc_q_sample_i;
	logic [5:0] first_correlator_out_i, second_correlator_out_i, minimum_level_threshold_i;
	logic production_test_i, sic_clock_i, error_indicator_bit_i;
	tsom_pkg::tsom_rate_type rate_i;
	tsom_pkg::tsom_phase_type tx_phase_i, rx_phase_i;
	logic [7:0] test_bus_i;
	logic first_observe_pin_oe_o, first_observe_pin_level_o, first_observe_pin_dac_enable_o;
	logic second_observe_pin_oe_o, second_observe_pin_level_o, second_observe_pin_dac_enable_o;
	logic [5:0] first_observe_pin_dac_code_o, second_observe_pin_dac_code_o;
	logic [8:0] seen1, seen2;
	int err_total = 0;
	int checks = 0;
	int cyc = 0;

	tsom_observe dut_u (.*);
	tsom_probe probe1_u (.oe_i(first_observe_pin_oe_o), .level_i(first_observe_pin_level_o),
		.dac_en_i(first_observe_pin_dac_enable_o), .code_i(first_observe_pin_dac_code_o), .seen_o(seen1));
	tsom_probe probe2_u (.oe_i(second_observe_pin_oe_o), .level_i(second_observe_pin_level_o),
		.dac_en_i(second_observe_pin_dac_enable_o), .code_i(second_observe_pin_dac_code_o), .seen_o(seen2));

	// clock and hang guard; the whole run needs well under a thousand cycles
	always #4 clock_i = ~clock_i;
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish

	task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// bus cycles hold until waitrequest is seen low, then let one edge pass
	task automatic bus_write(input logic [15:0] ix, input logic [7:0] d, input logic be);
		avs_address_i <= {ix, 2'h0};
		avs_writedata_i <= {24'h00_0000, d};
		avs_byteenable_i <= {3'h0, be};
		avs_write_i <= 1'b1;
		do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
		avs_write_i <= 1'b0;
		@(posedge clock_i);
	endtask : bus_write

	task automatic rd_chk(input string what, input logic [15:0] ix, input logic [7:0] exp);
		avs_address_i <= {ix, 2'h0};
		avs_read_i <= 1'b1;
		do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
		check(what, {1'b0, avs_readdata_o[7:0]}, {1'b0, exp});
		avs_read_i <= 1'b0;
		@(posedge clock_i);
	endtask : rd_chk

	// expected probe view {oe, dac, level, code}; lv holds the level sources of codes 8..F
	function automatic logic [8:0] exp_pin(input logic [3:0] c, input logic [5:0] own,
		input logic [7:0] lv);
		logic [6:0] s;
		s = {1'b0, adc_i_sample_i, 2'h0} + {1'b0, adc_q_sample_i, 2'h0};
		case (c)
			4'h0: exp_pin = 9'h000;
			4'h1: exp_pin = {3'h6, own};
			4'h2: exp_pin = {3'h6, first_correlator_out_i};
			4'h3: exp_pin = {3'h6, second_correlator_out_i};
			4'h4: exp_pin = {3'h6, minimum_level_threshold_i};
			4'h5: exp_pin = {3'h6, adc_i_sample_i, 2'h0};
			4'h6: exp_pin = {3'h6, adc_q_sample_i, 2'h0};
			4'h7: exp_pin = {3'h6, s[6:1]};
			default: exp_pin = {2'h2, lv[c[2:0]], 6'h00};
		endcase
	endfunction : exp_pin

	// select reset value, reserved bits, lane off and an unmapped place
	task automatic scen_regs;
		rd_chk("select reset", `TSOM_IDX_SELECT, 8'h00);
		bus_write(`TSOM_IDX_DAC1, 8'hFF, 1'b1);
		rd_chk("dac1 reserved", `TSOM_IDX_DAC1, 8'h3F);
		bus_write(`TSOM_IDX_DAC1, 8'h00, 1'b0);
		rd_chk("dac1 lane off", `TSOM_IDX_DAC1, 8'h3F);
		bus_write(16'h6340, 8'hFF, 1'b1);
		rd_chk("unmapped", 16'h6340, 8'h00);
		bus_write(`TSOM_IDX_DAC2, 8'hD3, 1'b1);
		rd_chk("dac2", `TSOM_IDX_DAC2, 8'h13);
		bus_write(`TSOM_IDX_DAC1, 8'h2C, 1'b1);
	endtask : scen_regs

	// every code on both pins, the two pins always on different codes
	task automatic scen_codes;
		bus_write(`TSOM_IDX_BUSBIT, 8'h06, 1'b1);
		for (int c = 0; c < 16; c++) begin
			bus_write(`TSOM_IDX_SELECT, {4'(c), 4'(15 - c)}, 1'b1);
			repeat (3) @(posedge clock_i);
			check("first pin", seen1, exp_pin(4'(c), 6'h2C, 8'hB5));
			check("second pin", seen2, exp_pin(4'(15 - c), 6'h13, 8'hB5));
		end
	endtask : scen_codes

	// frame strobes over every rate and phase; receive phase runs opposite to transmit
	task automatic scen_strobes;
		logic [7:0] tx, rx, sub;
		for (int pass = 0; pass < 2; pass++) begin
			bus_write(`TSOM_IDX_SELECT, pass ? 8'hEE : 8'hCD, 1'b1);
			for (int r = 0; r < 3; r++) begin
				tx = r ? 8'hBC : 8'hE2;
				rx = r ? 8'hA0 : 8'hE0;
				sub = r ? 8'hB8 : 8'h00;
				for (int p = 0; p < 8; p++) begin
					rate_i <= tsom_pkg::tsom_rate_type'(r);
					tx_phase_i <= tsom_pkg::tsom_phase_type'(p);
					rx_phase_i <= tsom_pkg::tsom_phase_type'(7 - p);
					repeat (3) @(posedge clock_i);
					if (pass) begin
						check("subcarrier", {8'h00, seen2[6]}, {8'h00, sub[7 - p]});
					end else begin
						check("transmit", {8'h00, seen1[6]}, {8'h00, tx[p]});
						check("receive", {8'h00, seen2[6]}, {8'h00, rx[7 - p]});
					end
				end
			end
		end
	endtask : scen_strobes

	// each bus bit choice, upper write bits set to show they are dropped
	task automatic scen_bus_bit;
		logic [7:0] pat;
		pat = 8'hA5;
		test_bus_i <= pat;
		bus_write(`TSOM_IDX_SELECT, 8'hFF, 1'b1);
		for (int b = 0; b < 8; b++) begin
			bus_write(`TSOM_IDX_BUSBIT, 8'(b) | 8'hF8, 1'b1);
			repeat (3) @(posedge clock_i);
			check("bus bit", {8'h00, seen1[6]}, {8'h00, pat[b]});
		end
		// first nibble cleared only: first pin lets go one cycle on, second stays put
		bus_write(`TSOM_IDX_SELECT, 8'h0F, 1'b1);
		@(posedge clock_i);
		check("first released", seen1, 9'h000);
		check("second kept", seen2, 9'h140);
		rd_chk("status", `TSOM_IDX_STATUS, 8'h18);
	endtask : scen_bus_bit

	initial begin
		clock_i = 1'b0;
		rst_i = 1'b1;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		avs_address_i = 18'h0_0000;
		avs_writedata_i = 32'h0000_0000;
		avs_byteenable_i = 4'h0;
		first_correlator_out_i = 6'h2A;
		second_correlator_out_i = 6'h15;
		minimum_level_threshold_i = 6'h33;
		adc_i_sample_i = 4'h9;
		adc_q_sample_i = 4'h6;
		production_test_i = 1'b1;
		sic_clock_i = 1'b0;
		error_indicator_bit_i = 1'b1;
		rate_i = tsom_pkg::TSOM_RATE_106;
		tx_phase_i = tsom_pkg::TSOM_PH_DATA;
		rx_phase_i = tsom_pkg::TSOM_PH_PARITY;
		test_bus_i = 8'h40;
		repeat (16) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		scen_regs();
		scen_codes();
		scen_strobes();
		scen_bus_bit();
		tally_and_finish();
	end
endmodule : test_test_signal_observe_mux
`default_nettype wire
